/* File: logic/amp_ctrl_pkg.sv */
// constants and types shared by the two-wire control slave
package amp_ctrl_pkg;
   // ==========================================================
   // timing
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int STD_SCL_HZ = 100_000;
   localparam int FAST_SCL_HZ = 400_000;
   localparam int FAST_SCL_HIGH_NS = 600;
   // shortest clock-high time in cycles, rounded down
   localparam int FAST_SCL_HIGH_CYC = FAST_SCL_HIGH_NS / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 3;
   // ==========================================================
   // bus framing
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [7:0] ADDR_BYTE_LOW = 8'h54;
   localparam logic [7:0] ADDR_BYTE_HIGH = 8'h56;
   // ==========================================================
   // subaddress space
   localparam logic [7:0] SUB_WORD_FIRST = 8'h20;
   localparam int WORD_BYTES = 4;
   localparam int MAX_REG_BYTES = 20;
   localparam int WORD_BITS = 32;
   // ==========================================================
   // protocol states
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK, ST_SUB, ST_WDATA, ST_RDATA, ST_MACK, ST_IGNORE
   } bus_state_t;
endpackage : amp_ctrl_pkg

/* File: logic/i2c_control_slave.sv */
// two-wire control slave: framing, addressing, subaddress write and read
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - works at 100 kHz and 400 kHz
// - slave only, never stretches the clock
// - bytes MSB first, each acknowledged once
// - acknowledge holds data low whole period
// - address 0x54 strap low, 0x56 high
// - unlimited bytes between start and stop
// - low subaddresses bytewise, high in 4-byte words
// - reads stream bytes while master acknowledges
// - unused read bits return zero
// - incomplete write discarded at stop/start
// - sequential write walks consecutive subaddresses
// - only last incomplete subaddress discarded
// - write: address, subaddress, data, all acknowledged
// - read: subaddress write, restart, read address
// - address strap sampled once after reset
module i2c_control_slave #(
   parameter int MAX_BYTES = amp_ctrl_pkg::MAX_REG_BYTES,
   parameter int BW = $clog2(MAX_BYTES + 1)
) (
   // clock and reset
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   // two-wire bus pins
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   // address strap
   input wire logic ADDRESS_SELECT_SHARED_PIN_IN,
   // register map lookup
   input wire logic [BW-1:0] REG_BYTES_IN,
   input wire logic [31:0] RD_WORD_IN,
   input wire logic [5:0] RD_BITS_IN,
   output logic [7:0] SUB_ADDR_OUT,
   output logic [BW-1:0] BYTE_IDX_OUT,
   // completed writes
   output logic WR_STB_OUT,
   output logic [7:0] WR_ADDR_OUT,
   output logic [BW-1:0] WR_LEN_OUT,
   output logic [MAX_BYTES*8-1:0] WR_DATA_OUT
);
   // ==========================================================
   // elaboration checks
   if (MAX_BYTES < amp_ctrl_pkg::WORD_BYTES || MAX_BYTES % amp_ctrl_pkg::WORD_BYTES != 0) begin
      $error("MAX_BYTES must be a positive multiple of four");
   end
   if (amp_ctrl_pkg::FAST_SCL_HIGH_CYC <= amp_ctrl_pkg::SYNC_STAGES + 2) begin
      $error("clock too slow for fast-mode sampling");
   end

   amp_ctrl_pkg::bus_state_t state_r;
   amp_ctrl_pkg::bus_state_t after_r;
   logic scl_lvl, scl_rise, scl_fall;
   logic sda_lvl, sda_rise, sda_fall;
   logic sel_lvl;
   logic [3:0] bit_cnt_r;
   logic [7:0] sh_r;
   logic [7:0] tx_r;
   logic nack_r;
   logic [7:0] dev_addr_r;
   logic [2:0] strap_cnt_r;
   logic strap_done_r;
   logic [BW-1:0] wcnt_r;
   logic [MAX_BYTES*8-1:0] wbuf_r;
   logic start_ev, stop_ev, byte_end;
   logic [BW-1:0] cur_len;
   logic [7:0] rd_byte;

   // ==========================================================
   // pin synchronisers
   pin_sync3 #(.RST_VAL(1'b1)) u_scl (
      .clk_in(MCLK_IN), .rst_n_in(RST_N_IN), .pin_in(SCL_IN),
      .level_out(scl_lvl), .rise_out(scl_rise), .fall_out(scl_fall));
   pin_sync3 #(.RST_VAL(1'b1)) u_sda (
      .clk_in(MCLK_IN), .rst_n_in(RST_N_IN), .pin_in(SDA_IN),
      .level_out(sda_lvl), .rise_out(sda_rise), .fall_out(sda_fall));
   pin_sync3 #(.RST_VAL(1'b0)) u_sel (
      .clk_in(MCLK_IN), .rst_n_in(RST_N_IN), .pin_in(ADDRESS_SELECT_SHARED_PIN_IN),
      .level_out(sel_lvl), .rise_out(), .fall_out());

   // ==========================================================
   // helpers
   // bytes that make one subaddress complete
   function automatic logic [BW-1:0] reg_len(input logic [7:0] sub, input logic [BW-1:0] n);
      logic [BW:0] up;
      up = {1'b0, n} + (BW+1)'(3);
      if (sub < amp_ctrl_pkg::SUB_WORD_FIRST) begin
         reg_len = (n == '0) ? BW'(1) : n;
      end else begin
         reg_len = (n == '0) ? BW'(amp_ctrl_pkg::WORD_BYTES) : {up[BW-1:2], 2'b00};
      end
   endfunction : reg_len

   // byte of the word, MSB first, unused bits forced to zero
   function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [5:0] bits,
                                            input logic [BW-1:0] len, input logic [BW-1:0] idx);
      logic [32:0] mask;
      logic [31:0] m;
      logic [1:0] sel;
      mask = (33'h1_0000_0000 >> (6'd32 - bits)) - 33'h0_0000_0001;
      if (bits >= 6'd32) begin
         mask = 33'h0_FFFF_FFFF;
      end
      m = w & mask[31:0];
      sel = 2'(len - BW'(1) - idx);
      pick_byte = 8'(m >> {sel, 3'b000});
   endfunction : pick_byte

   // ==========================================================
   // bus events; start and stop only count with clock high
   assign start_ev = sda_fall && scl_lvl;
   assign stop_ev = sda_rise && scl_lvl;
   assign byte_end = scl_fall && (bit_cnt_r == amp_ctrl_pkg::BYTE_BITS);
   assign cur_len = reg_len(SUB_ADDR_OUT, REG_BYTES_IN);
   assign rd_byte = pick_byte(RD_WORD_IN, RD_BITS_IN, cur_len, BYTE_IDX_OUT);

   // ==========================================================
   // strap capture a few cycles after reset, then frozen
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         strap_cnt_r <= 3'h0;
         strap_done_r <= 1'b0;
         dev_addr_r <= amp_ctrl_pkg::ADDR_BYTE_LOW;
      end else if (!strap_done_r) begin
         strap_cnt_r <= strap_cnt_r + 3'h1;
         // filtered level only settles one cycle past the three flops; wait one more for margin
         if (strap_cnt_r == 3'(amp_ctrl_pkg::SYNC_STAGES + 2)) begin
            strap_done_r <= 1'b1;
            dev_addr_r <= sel_lvl ? amp_ctrl_pkg::ADDR_BYTE_HIGH
                                  : amp_ctrl_pkg::ADDR_BYTE_LOW;
         end
      end
   end

   // ==========================================================
   // protocol engine; only data is driven, never the clock
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         state_r <= amp_ctrl_pkg::ST_IDLE;
         after_r <= amp_ctrl_pkg::ST_IDLE;
         bit_cnt_r <= 4'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         nack_r <= 1'b0;
         SDA_OE_OUT <= 1'b0;
         SDA_OUT <= 1'b0;
      end else begin
         SDA_OUT <= 1'b0; // open drain: only ever pulls low
         if (start_ev) begin
            state_r <= amp_ctrl_pkg::ST_ADDR;
            bit_cnt_r <= 4'h0;
            SDA_OE_OUT <= 1'b0;
         end else if (stop_ev) begin
            state_r <= amp_ctrl_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            SDA_OE_OUT <= 1'b0;
         end else begin
            case (state_r)
               amp_ctrl_pkg::ST_ADDR, amp_ctrl_pkg::ST_SUB, amp_ctrl_pkg::ST_WDATA: begin
                  if (scl_rise) begin
                     sh_r <= {sh_r[6:0], sda_lvl};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else if (byte_end) begin
                     bit_cnt_r <= 4'h0;
                     if (state_r != amp_ctrl_pkg::ST_ADDR) begin
                        SDA_OE_OUT <= 1'b1;
                        state_r <= amp_ctrl_pkg::ST_ACK;
                        after_r <= amp_ctrl_pkg::ST_WDATA;
                     end else if (sh_r[7:1] == dev_addr_r[7:1]) begin
                        SDA_OE_OUT <= 1'b1;
                        state_r <= amp_ctrl_pkg::ST_ACK;
                        after_r <= sh_r[0] ? amp_ctrl_pkg::ST_RDATA
                                           : amp_ctrl_pkg::ST_SUB;
                     end else begin
                        state_r <= amp_ctrl_pkg::ST_IGNORE;
                     end
                  end
               end
               amp_ctrl_pkg::ST_ACK: begin
                  // held low through the whole acknowledge clock
                  if (scl_fall) begin
                     state_r <= after_r;
                     if (after_r == amp_ctrl_pkg::ST_RDATA) begin
                        tx_r <= rd_byte;
                        SDA_OE_OUT <= ~rd_byte[7];
                     end else begin
                        SDA_OE_OUT <= 1'b0;
                     end
                  end
               end
               amp_ctrl_pkg::ST_RDATA: begin
                  if (scl_rise) begin
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else if (byte_end) begin
                     bit_cnt_r <= 4'h0;
                     SDA_OE_OUT <= 1'b0;
                     state_r <= amp_ctrl_pkg::ST_MACK;
                  end else if (scl_fall) begin
                     tx_r <= {tx_r[6:0], 1'b0};
                     SDA_OE_OUT <= ~tx_r[6];
                  end
               end
               amp_ctrl_pkg::ST_MACK: begin
                  if (scl_rise) begin
                     nack_r <= sda_lvl;
                  end else if (scl_fall) begin
                     if (nack_r) begin
                        state_r <= amp_ctrl_pkg::ST_IGNORE;
                     end else begin
                        state_r <= amp_ctrl_pkg::ST_RDATA;
                        tx_r <= rd_byte;
                        SDA_OE_OUT <= ~rd_byte[7];
                     end
                  end
               end
               default: begin
                  bit_cnt_r <= 4'h0;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // subaddress pointer, write assembly and commit
   // partial data never leaves wbuf_r, so a cut-off write just vanishes
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         SUB_ADDR_OUT <= 8'h00;
         BYTE_IDX_OUT <= '0;
         wcnt_r <= '0;
         wbuf_r <= '0;
         WR_STB_OUT <= 1'b0;
         WR_ADDR_OUT <= 8'h00;
         WR_LEN_OUT <= '0;
         WR_DATA_OUT <= '0;
      end else begin
         WR_STB_OUT <= 1'b0;
         if (start_ev || stop_ev) begin
            wcnt_r <= '0;
         end else if (byte_end && state_r == amp_ctrl_pkg::ST_SUB) begin
            SUB_ADDR_OUT <= sh_r;
            BYTE_IDX_OUT <= '0;
            wcnt_r <= '0;
         end else if (byte_end && state_r == amp_ctrl_pkg::ST_WDATA) begin
            wbuf_r <= {wbuf_r[MAX_BYTES*8-9:0], sh_r};
            if (wcnt_r + BW'(1) >= cur_len) begin
               WR_STB_OUT <= 1'b1;
               WR_ADDR_OUT <= SUB_ADDR_OUT;
               WR_LEN_OUT <= cur_len;
               WR_DATA_OUT <= {wbuf_r[MAX_BYTES*8-9:0], sh_r};
               SUB_ADDR_OUT <= SUB_ADDR_OUT + 8'h01;
               wcnt_r <= '0;
            end else begin
               wcnt_r <= wcnt_r + BW'(1);
            end
         end else if (state_r == amp_ctrl_pkg::ST_MACK && scl_rise && !sda_lvl) begin
            if (BYTE_IDX_OUT + BW'(1) >= cur_len) begin
               SUB_ADDR_OUT <= SUB_ADDR_OUT + 8'h01;
               BYTE_IDX_OUT <= '0;
            end else begin
               BYTE_IDX_OUT <= BYTE_IDX_OUT + BW'(1);
            end
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);

   sequence s_byte_done;
      byte_end;
   endsequence
   sequence s_bad_addr;
      state_r == amp_ctrl_pkg::ST_ADDR && sh_r[7:1] != dev_addr_r[7:1] ##0 s_byte_done;
   endsequence

   AST_DRIVE_ON_LOW: assert property ($rose(SDA_OE_OUT) |-> $past(scl_fall))
      else $error("data driven outside clock low");
   AST_ACK_HELD: assert property (state_r == amp_ctrl_pkg::ST_ACK |-> SDA_OE_OUT)
      else $error("acknowledge released early");
   AST_MISMATCH: assert property (s_bad_addr |=> state_r == amp_ctrl_pkg::ST_IGNORE
                                  && !SDA_OE_OUT)
      else $error("foreign address answered");
   AST_ADDR_SET: assert property (strap_done_r |-> dev_addr_r == amp_ctrl_pkg::ADDR_BYTE_LOW
                                  || dev_addr_r == amp_ctrl_pkg::ADDR_BYTE_HIGH)
      else $error("bad device address");
   AST_STRAP_FROZEN: assert property (strap_done_r && $past(strap_done_r) |-> $stable(dev_addr_r))
      else $error("address changed after capture");
   AST_SEQ_WALK: assert property (WR_STB_OUT |-> SUB_ADDR_OUT == WR_ADDR_OUT + 8'h01)
      else $error("write pointer did not advance");
   AST_DISCARD: assert property (start_ev || stop_ev |=> wcnt_r == '0 && !WR_STB_OUT)
      else $error("partial write kept");
   AST_WORD_LEN: assert property (WR_STB_OUT && WR_ADDR_OUT >= amp_ctrl_pkg::SUB_WORD_FIRST
                                  |-> WR_LEN_OUT[1:0] == 2'b00)
      else $error("high subaddress not whole words");
   AST_READ_ADV: assert property (state_r == amp_ctrl_pkg::ST_MACK && scl_rise && !sda_lvl
      |=> BYTE_IDX_OUT == $past(BYTE_IDX_OUT) + BW'(1)
          || (BYTE_IDX_OUT == '0 && SUB_ADDR_OUT == $past(SUB_ADDR_OUT) + 8'h01))
      else $error("read pointer stuck");
   AST_BITS: assert property (bit_cnt_r <= amp_ctrl_pkg::BYTE_BITS)
      else $error("bit counter overrun");
   AST_TX_BIT: assert property (state_r == amp_ctrl_pkg::ST_RDATA && !$rose(state_r == amp_ctrl_pkg::ST_RDATA)
                                |-> SDA_OE_OUT == ~tx_r[7])
      else $error("transmit bit mismatch");
   AST_ACK_WINDOW: assert property (s_byte_done ##0 state_r == amp_ctrl_pkg::ST_WDATA
                                    |=> SDA_OE_OUT [*2])
      else $error("write byte not acknowledged");
endmodule : i2c_control_slave
`default_nettype wire

/* File: logic/pin_sync3.sv */
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
   parameter logic RST_VAL = 1'b1
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // pin side
   input wire logic pin_in,
   // filtered side
   output logic level_out,
   output logic rise_out,
   output logic fall_out
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic agree;

   // ==========================================================
   // capture chain; first stage feeds only the second
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign agree = (s2_r == s3_r);

   // ==========================================================
   // a change counts once stages two and three agree
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         level_out <= RST_VAL;
         rise_out <= 1'b0;
         fall_out <= 1'b0;
      end else begin
         rise_out <= agree && s3_r && !level_out;
         fall_out <= agree && !s3_r && level_out;
         if (agree) begin
            level_out <= s3_r;
         end
      end
   end
endmodule : pin_sync3
`default_nettype wire

/* File: verification/i2c_master_model.sv */
// behavioural two-wire bus master that stands opposite the control slave
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   // clock used only for pacing
   input wire logic clk_in,
   // bus wires
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   int half_cyc = 63; // about 397 kHz
   int clash = 0;
   // idle bus: both wires left to the pull-ups
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   // ==========================================================
   // bit level
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask : tick
   // data moves 300 ns into the low phase, past the slave's seen fall
   task automatic put_bit(input logic b, output logic seen);
      scl_out = 1'b0;
      tick(15);
      sda_oe_out = ~b;
      tick(half_cyc - 15);
      scl_out = 1'b1;
      tick(half_cyc / 2);
      seen = sda_in;
      tick(half_cyc - half_cyc / 2);
      if (sda_in !== seen) clash++;
   endtask : put_bit
   // ==========================================================
   // framing; clock is pulled low first so a repeated start is not a stop
   task automatic start();
      scl_out = 1'b0;
      tick(15);
      sda_oe_out = 1'b0;
      tick(half_cyc);
      scl_out = 1'b1;
      tick(half_cyc);
      sda_oe_out = 1'b1;
      tick(half_cyc);
   endtask : start
   task automatic stop();
      scl_out = 1'b0;
      tick(15);
      sda_oe_out = 1'b1;
      tick(half_cyc);
      scl_out = 1'b1;
      tick(half_cyc);
      sda_oe_out = 1'b0;
      tick(half_cyc);
   endtask : stop
   // ==========================================================
   // byte level, most significant bit first
   task automatic write_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(v[i], s);
         if (s !== v[i]) clash++;
      end
      put_bit(1'b1, ack);
   endtask : write_byte
   task automatic read_byte(input logic mack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, v[i]);
      end
      put_bit(~mack, s);
   endtask : read_byte
endmodule : i2c_master_model
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the two-wire control slave
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk, rst_n, strap, scl, sda, m_oe, sda_o, sda_oe, wr_stb;
   logic [4:0] reg_bytes, idx, wr_len;
   logic [31:0] rd_word;
   logic [5:0] rd_bits;
   logic [7:0] sub, wr_addr, b;
   logic [159:0] wr_data, last_data;
   logic [12:0] stb_q [$];
   int num_errors = 0;
   int checks = 0;
   // wired-and bus with pull-up
   assign sda = (sda_oe ? sda_o : 1'b1) & ~m_oe;
   // register map stand-in: sizes and contents per subaddress
   always_comb begin
      if (sub < 8'h20) reg_bytes = (sub >= 8'h07 && sub <= 8'h0a) ? 5'h2 : 5'h1;
      else reg_bytes = (sub == 8'h26) ? 5'h14 : 5'h4;
      rd_word = {sub, ~sub, 8'ha5, sub ^ 8'h3c};
      rd_bits = (sub == 8'h21) ? 6'h10 : 6'h20;
   end
   // completed-write log, read away from the launching edge
   always @(negedge clk) begin
      if (wr_stb === 1'b1) begin
         stb_q.push_back({wr_addr, wr_len});
         last_data = wr_data;
      end
   end
   i2c_master_model i_master (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
   i2c_control_slave i_dut (
      .MCLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
      .SDA_OE_OUT(sda_oe), .ADDRESS_SELECT_SHARED_PIN_IN(strap), .REG_BYTES_IN(reg_bytes),
      .RD_WORD_IN(rd_word), .RD_BITS_IN(rd_bits), .SUB_ADDR_OUT(sub), .BYTE_IDX_OUT(idx),
      .WR_STB_OUT(wr_stb), .WR_ADDR_OUT(wr_addr), .WR_LEN_OUT(wr_len), .WR_DATA_OUT(wr_data));
   // ==========================================================
   // helpers
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   // strap must stay put through the capture after release
   task automatic do_reset(input logic s);
      @(negedge clk);
      rst_n = 1'b0;
      strap = s;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (12) @(negedge clk);
   endtask : do_reset
   task automatic wr(input logic [7:0] v, input logic ak);
      logic a;
      i_master.write_byte(v, a);
      check(a, !ak);
   endtask : wr
   task automatic xfer(input logic [7:0] dev, input logic [7:0] s, input int n,
                       input logic [7:0] d0, input logic ak, input logic fin);
      i_master.start();
      wr(dev, ak);
      wr(s, ak);
      for (int i = 0; i < n; i++) begin
         wr(d0 + 8'(i), ak);
      end
      if (fin) i_master.stop();
   endtask : xfer
   function automatic logic [7:0] exp_rd(input logic [7:0] s, input int i);
      logic [31:0] w;
      w = {s, ~s, 8'ha5, s ^ 8'h3c};
      if (s == 8'h21) w[31:16] = 16'h0000; // only the low half is real
      return w[8*(3-i) +: 8];
   endfunction : exp_rd
   // ==========================================================
   // scenarios
   task automatic t_single;
      stb_q.delete();
      xfer(8'h54, 8'h03, 1, 8'hab, 1'b1, 1'b1);
      check(stb_q.size(), 1);
      check(stb_q[0], {8'h03, 5'h1});
      check(last_data[7:0], 8'hab);
   endtask : t_single
   task automatic t_seq;
      stb_q.delete();
      xfer(8'h54, 8'h06, 4, 8'h10, 1'b1, 1'b1);
      check(stb_q.size(), 2);
      check(stb_q[1], {8'h07, 5'h2});
      check(last_data[15:0], 16'h1112);
      stb_q.delete();
      xfer(8'h54, 8'h10, 16, 8'h40, 1'b1, 1'b1);
      check(stb_q.size(), 16);
      check(stb_q[15], {8'h1f, 5'h1});
      check(sub, 8'h20);
   endtask : t_seq
   task automatic t_word;
      stb_q.delete();
      xfer(8'h54, 8'h20, 6, 8'h60, 1'b1, 1'b0);
      xfer(8'h54, 8'h26, 20, 8'h80, 1'b1, 1'b1);
      check(stb_q.size(), 2);
      check(stb_q[0], {8'h20, 5'h4});
      check(stb_q[1], {8'h26, 5'h14});
      check({last_data[159:152], last_data[7:0]}, 16'h8093);
      xfer(8'h54, 8'h26, 5, 8'ha0, 1'b1, 1'b0);
      xfer(8'h54, 8'h21, 2, 8'hb0, 1'b1, 1'b1);
      check(stb_q.size(), 2);
   endtask : t_word
   task automatic t_read;
      xfer(8'h54, 8'h20, 0, 8'h00, 1'b1, 1'b0);
      i_master.start();
      wr(8'h55, 1'b1);
      for (int i = 0; i < 6; i++) begin
         i_master.read_byte(i < 5, b);
         check(b, exp_rd(i < 4 ? 8'h20 : 8'h21, i % 4));
      end
      i_master.stop();
      check(sub, 8'h21);
      check(idx, 5'h01);
   endtask : t_read
   task automatic t_mismatch;
      stb_q.delete();
      xfer(8'h56, 8'h03, 1, 8'h00, 1'b0, 1'b1);
      check(stb_q.size(), 0);
   endtask : t_mismatch
   // strap high, then the shared pin moves on; standard-mode rate
   task automatic t_strap_high;
      do_reset(1'b1);
      strap = 1'b0;
      stb_q.delete();
      i_master.half_cyc = 250;
      xfer(8'h56, 8'h05, 1, 8'h5a, 1'b1, 1'b1);
      check(stb_q[0], {8'h05, 5'h1});
      i_master.half_cyc = 63;
      i_master.start();
      wr(8'h54, 1'b0);
      i_master.stop();
   endtask : t_strap_high
   // ==========================================================
   // main sequence and watchdog
   initial begin
      rst_n = 1'b0;
      strap = 1'b0;
      do_reset(1'b0);
      t_single();
      t_seq();
      t_word();
      t_read();
      t_mismatch();
      t_strap_high();
      check(i_master.clash, 0);
      stop_test();
   end
   initial begin
      #3_000_000;
      num_errors++;
      stop_test();
   end
endmodule : tb
`default_nettype wire
